// File: include/task_file_regs.vh
// Register offsets, field positions and reset values of the task-file bank
`ifndef TASK_FILE_REGS_VH
`define TASK_FILE_REGS_VH

// =====================================================================
// Register offsets (4-bit task-file offset)
`define TF_OFS_DATA       4'h0
`define TF_OFS_ERROR      4'h1
`define TF_OFS_COUNT      4'h2
`define TF_OFS_ADDR_LOW   4'h3
`define TF_OFS_ADDR_MID   4'h4
`define TF_OFS_ADDR_HIGH  4'h5
`define TF_OFS_UNIT_HEAD  4'h6
`define TF_OFS_STATUS     4'h7
`define TF_OFS_ERROR_DUP  4'hD
`define TF_OFS_SHADOW     4'hE
`define TF_OFS_READBACK   4'hF

// =====================================================================
// Error cause bit positions
`define ERR_BAD_BLOCK     7
`define ERR_UNCORRECTABLE 6
`define ERR_NOT_FOUND     4
`define ERR_ABORTED       2
`define ERR_GENERAL       0
`define ERR_LIVE_MASK     8'hD5

// =====================================================================
// Unit/head select bit positions
`define UH_LBA_MODE       6
`define UH_DRIVE          4
`define UH_FORCED_ONES    8'hA0

// =====================================================================
// Status bit positions
`define ST_BUSY           7
`define ST_READY          6
`define ST_WRITE_FAULT    5
`define ST_SETTLED        4
`define ST_TRANSFER       3
`define ST_CORRECTED      2
`define ST_INDEX          1
`define ST_ERROR          0

// =====================================================================
// Host control bit positions
`define HC_SOFT_RESET     2
`define HC_IRQ_DISABLE    1

// =====================================================================
// Reset values
`define COUNT_RESET       8'h01
`define BYTE_ZERO         8'h00
`define SECTORS_FULL      9'h100

`endif

// File: hdl/pin_sync.v
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter RESET_LEVEL = 1'b0  // Level shown before the first agreement
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire pin,
  output reg level_q
);

  reg s1_q;  // First stage, read only by s2_q
  reg s2_q;  // Second stage
  reg s3_q;  // Third stage

  // =====================================================================
  // Shift chain and filter
  // A change counts only once stages two and three agree
  always @(posedge clk) begin
    if (rst) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule // pin_sync

`default_nettype wire

// File: hdl/ata_task_file_registers.v
// Task-file register bank of a removable flash storage card
// Function
// - Read-only error cause register at offsets 1, D
// - Bit 7 bad block, bit 6 uncorrectable
// - Bit 4 sector id not found
// - Bit 2 command aborted or invalid
// - Bit 0 general error; 5,3,1 zero
// - Odd-only byte at offset 0 uses D15-D8
// - Transfer count zero means 256 sectors
// - Count resets 01h, zero on success
// - Unit/head bit 6 picks CHS or LBA
// - LBA built from four address registers
// - Bits 7,5 read one; bit 4 drive
// - Primary status read clears pending interrupt
// - Busy set while card owns command path
// - Ready clear from power-up until able
// - Bit 5 write fault, bit 4 settled
// - Transfer request set on need, next command clears
// - Bit 2 corrected error; bit 1 zero
// - Error bit per command; failing address kept
// - Host control writable even while busy
// - Soft reset bit holds reset, loads diagnostic
// - Control bit 1 disables interrupt, resets 0
// - Readback shows write, inverted head, selection
`timescale 1ns/1ps
`default_nettype none
`include "task_file_regs.vh"

module ata_task_file_registers #(
  parameter [7:0] DIAG_CODE = 8'h01  // Diagnostic code after soft reset
) (
  input wire clk,
  input wire rst,
  input wire ce,
  // Host side of the task file (already captured into clk domain)
  input wire host_rd,            // One-cycle read strobe
  input wire host_wr,            // One-cycle write strobe
  input wire [3:0] host_offset,  // Task-file offset
  input wire even_byte_n,        // Even-byte enable, active low
  input wire odd_byte_n,         // Odd-byte enable, active low
  input wire [15:0] host_wdata,  // Write data D15-D0
  output reg [15:0] host_rdata,  // Read data D15-D0
  output reg host_rdata_oe,      // High while card drives the bus
  // Configuration pin, copy number (outside domain)
  input wire copy_number_pin,
  // Controller side
  input wire cmd_start,          // New command written to command reg
  input wire busy_set,           // Card takes command path
  input wire busy_clear,         // Card releases command path
  input wire ready_set,          // Card can accept commands
  input wire xfer_req_set,       // Data register transfer needed
  input wire xfer_req_clear,     // Transfer phase over
  input wire corrected_set,      // Data error corrected
  input wire write_fault_set,    // Write fault occurred
  input wire write_active,       // Write in progress
  input wire cmd_done,           // Command ended (pulse)
  input wire cmd_failed,         // With cmd_done: ended in error
  input wire [7:0] fail_cause,   // Error cause bits for failure
  input wire [7:0] remain_count, // Sectors left on failure
  input wire [27:0] fail_addr,   // First failing sector address
  input wire irq_event,          // Completion interrupt event
  output reg [7:0] feature_q,    // Feature code for the controller
  output reg [7:0] count_q,      // Raw transfer count
  output reg [8:0] sectors_q,    // Effective sector count 1..256
  output reg lba_mode_q,         // High: logical block addressing
  output reg [27:0] start_addr_q,// Start address, LBA or CHS packed
  output reg selected_q,         // Drive bit matches copy number
  output reg soft_reset_q,       // Card held in soft reset
  output reg irq_q               // Interrupt request, active high
);

  // =====================================================================
  // Storage
  reg [7:0] error_q;     // Error cause register
  reg [7:0] addr_low_q;  // Start address low
  reg [7:0] addr_mid_q;  // Start address mid
  reg [7:0] addr_high_q; // Start address high
  reg [7:0] unit_head_q; // Unit/head select, writable bits
  reg [7:0] status_q;    // Status register
  reg irq_disable_q;     // Host control interrupt disable
  reg irq_pending_q;     // Interrupt awaiting status read
  wire copy_number;      // Synchronised copy number
  wire write_busy;       // Write activity, same clock, not synchronised

  // Copy number comes from a pin, so filter it
  pin_sync #(.RESET_LEVEL(1'b0)) u_copy_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(copy_number_pin),
    .level_q(copy_number)
  );

  assign write_busy = write_active;  // Same-clock logic, no sync

  // =====================================================================
  // Access decode
  // Odd-only byte to offset 0 is the error/feature register on D15-D8
  wire odd_only = even_byte_n & ~odd_byte_n;
  wire alias_err = (host_offset == `TF_OFS_DATA) & odd_only;
  wire hit_err = (host_offset == `TF_OFS_ERROR) |
                 (host_offset == `TF_OFS_ERROR_DUP) | alias_err;
  // Byte lane: odd-only accesses use the upper lane
  wire [7:0] wbyte = odd_only ? host_wdata[15:8] : host_wdata[7:0];
  wire wr_ok = host_wr & ~status_q[`ST_BUSY];  // Task file locked
  wire wr_ctl = host_wr & (host_offset == `TF_OFS_SHADOW);

  // =====================================================================
  // Read mux
  reg [7:0] rbyte;
  always @* begin
    rbyte = `BYTE_ZERO;
    if (hit_err) begin
      rbyte = error_q & `ERR_LIVE_MASK;
    end else begin
      case (host_offset)
        `TF_OFS_COUNT: rbyte = count_q;
        `TF_OFS_ADDR_LOW: rbyte = addr_low_q;
        `TF_OFS_ADDR_MID: rbyte = addr_mid_q;
        `TF_OFS_ADDR_HIGH: rbyte = addr_high_q;
        `TF_OFS_UNIT_HEAD: rbyte = unit_head_q | `UH_FORCED_ONES;
        `TF_OFS_STATUS: rbyte = status_q;
        `TF_OFS_SHADOW: rbyte = status_q;
        `TF_OFS_READBACK: begin
          // Bit 7 left zero; inverted head and selection
          rbyte = {1'b0, ~write_busy, ~unit_head_q[3:0],
                   ~(selected_q & unit_head_q[`UH_DRIVE]),
                   ~(selected_q & ~unit_head_q[`UH_DRIVE])};
        end
        default: rbyte = `BYTE_ZERO;  // Data path lives elsewhere
      endcase
    end
  end

  // =====================================================================
  // Read data register, lane follows byte enables
  always @(posedge clk) begin
    if (rst) begin
      host_rdata <= 16'h0000;
      host_rdata_oe <= 1'b0;
    end else if (ce) begin
      host_rdata_oe <= host_rd;
      if (host_rd) begin
        host_rdata <= odd_only ? {rbyte, 8'h00} : {8'h00, rbyte};
      end
    end
  end

  // =====================================================================
  // Host control: soft reset and interrupt disable, writable any time
  always @(posedge clk) begin
    if (rst) begin
      soft_reset_q <= 1'b0;
      irq_disable_q <= 1'b0;  // Enabled at power-on
    end else if (ce && wr_ctl) begin
      soft_reset_q <= wbyte[`HC_SOFT_RESET];
      irq_disable_q <= wbyte[`HC_IRQ_DISABLE];
    end
  end

  // =====================================================================
  // Task-file parameter registers
  // Controller results take priority over host writes in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      feature_q <= `BYTE_ZERO;
      count_q <= `COUNT_RESET;
      addr_low_q <= `BYTE_ZERO;
      addr_mid_q <= `BYTE_ZERO;
      addr_high_q <= `BYTE_ZERO;
      unit_head_q <= `BYTE_ZERO;
      error_q <= `BYTE_ZERO;
    end else if (ce) begin
      if (soft_reset_q) begin
        error_q <= DIAG_CODE;  // Diagnostic code held in reset
        count_q <= `COUNT_RESET;
      end else if (cmd_done) begin
        if (cmd_failed) begin
          error_q <= fail_cause &
                     `ERR_LIVE_MASK;
          count_q <= remain_count;
          // Leave first failing sector address
          addr_low_q <= fail_addr[7:0];
          addr_mid_q <= fail_addr[15:8];
          addr_high_q <= fail_addr[23:16];
          unit_head_q[3:0] <= fail_addr[27:24];
        end else begin
          count_q <= `BYTE_ZERO;  // Success leaves zero
        end
      end else if (cmd_start) begin
        error_q <= `BYTE_ZERO;
      end else if (wr_ok) begin
        if (hit_err) begin
          feature_q <= wbyte;
        end
        case (host_offset)
          `TF_OFS_COUNT: count_q <= wbyte;
          `TF_OFS_ADDR_LOW: addr_low_q <= wbyte;
          `TF_OFS_ADDR_MID: addr_mid_q <= wbyte;
          `TF_OFS_ADDR_HIGH: addr_high_q <= wbyte;
          `TF_OFS_UNIT_HEAD: unit_head_q <= wbyte & ~`UH_FORCED_ONES;
          default: ;  // Other offsets hold no parameter
        endcase
      end
    end
  end

  // =====================================================================
  // Decoded parameters for the controller
  always @(posedge clk) begin
    if (rst) begin
      sectors_q <= 9'h001;
      lba_mode_q <= 1'b0;
      start_addr_q <= 28'h0000000;
      selected_q <= 1'b0;
    end else if (ce) begin
      // Zero count asks for a full 256 sectors
      sectors_q <= (count_q == `BYTE_ZERO) ? `SECTORS_FULL
                                           : {1'b0, count_q};
      lba_mode_q <= unit_head_q[`UH_LBA_MODE];
      // Same packing serves CHS: head, cylinder, sector
      start_addr_q <= {unit_head_q[3:0], addr_high_q, addr_mid_q,
                       addr_low_q};
      selected_q <= (unit_head_q[`UH_DRIVE] == copy_number);
    end
  end

  // =====================================================================
  // Status register; set beats clear in the same cycle, soft reset beats both and clears all
  always @(posedge clk) begin
    if (rst) begin
      status_q <= `BYTE_ZERO;  // Ready clear at power-up
    end else if (ce) begin
      if (soft_reset_q) begin
        status_q <= `BYTE_ZERO;  // Cleared while held
      end else begin
        // Busy owns command path
        if (busy_set | cmd_start) begin
          status_q[`ST_BUSY] <= 1'b1;
        end else if (busy_clear) begin
          status_q[`ST_BUSY] <= 1'b0;
        end
        if (ready_set) begin
          status_q[`ST_READY] <= 1'b1;
          status_q[`ST_SETTLED] <= 1'b1;
        end
        if (write_fault_set) begin
          status_q[`ST_WRITE_FAULT] <= 1'b1;
        end else if (cmd_start) begin
          status_q[`ST_WRITE_FAULT] <= 1'b0;
        end
        if (xfer_req_set) begin
          status_q[`ST_TRANSFER] <= 1'b1;
        end else if (cmd_start | xfer_req_clear) begin
          status_q[`ST_TRANSFER] <= 1'b0;
        end
        if (corrected_set) begin
          status_q[`ST_CORRECTED] <= 1'b1;
        end else if (cmd_start) begin
          status_q[`ST_CORRECTED] <= 1'b0;
        end
        status_q[`ST_INDEX] <= 1'b0;  // Always zero
        if (cmd_done & cmd_failed) begin
          status_q[`ST_ERROR] <= 1'b1;
        end else if (cmd_start) begin
          status_q[`ST_ERROR] <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // Interrupt: primary status read clears, shadow read does not
  wire status_rd = host_rd & (host_offset == `TF_OFS_STATUS) & ~odd_only;
  always @(posedge clk) begin
    if (rst) begin
      irq_pending_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      if (soft_reset_q) begin
        irq_pending_q <= 1'b0;
      end else if (irq_event) begin
        irq_pending_q <= 1'b1;  // Event wins over a same-cycle read
      end else if (status_rd) begin
        irq_pending_q <= 1'b0;
      end
      irq_q <= irq_pending_q & ~irq_disable_q;
    end
  end

endmodule // ata_task_file_registers

`default_nettype wire

// File: sim/tf_checker_properties.sv
// Port-level assertions for the task-file register bank
`timescale 1ns/1ps
`default_nettype none
module tf_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [3:0] host_offset,
  input wire logic even_byte_n,
  input wire logic [15:0] host_wdata,
  input wire logic host_rdata_oe,
  input wire logic cmd_done,
  input wire logic cmd_failed,
  input wire logic [7:0] remain_count,
  input wire logic irq_event,
  input wire logic [7:0] count_q,
  input wire logic [8:0] sectors_q,
  input wire logic soft_reset_q,
  input wire logic irq_q
);
  // ===================================================================
  // Shared clocking, one domain only
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Even-lane write to the control offset
  wire ctl_wr = ce && host_wr && host_offset == 4'hE && !even_byte_n;
  // Done without soft reset in the way
  wire done_ok = ce && cmd_done && !soft_reset_q;
  // ===================================================================
  // Properties
  oe_track_a: assert property (
    ce |=> host_rdata_oe == $past(host_rd))
    else $error("read enable does not follow the read strobe");
  zero_count_a: assert property (
    ce && count_q == 8'h00 |=> sectors_q == 9'h100)
    else $error("zero count not decoded as full count");
  plain_count_a: assert property (
    ce && count_q != 8'h00 |=> sectors_q == {1'b0, $past(count_q)})
    else $error("sector count decode wrong");
  done_clear_a: assert property (
    done_ok && !cmd_failed |=> count_q == 8'h00)
    else $error("count not cleared on success");
  fail_count_a: assert property (
    done_ok && cmd_failed |=> count_q == $past(remain_count))
    else $error("count does not hold remaining sectors");
  hold_count_a: assert property (
    soft_reset_q && $past(soft_reset_q) |-> count_q == 8'h01)
    else $error("count not at default during soft reset");
  soft_enter_a: assert property (
    ctl_wr && host_wdata[2] |=> soft_reset_q)
    else $error("soft reset not entered");
  status_clear_a: assert property (
    ce && host_rd && host_offset == 4'h7 && !even_byte_n && !irq_event
    |-> ##2 !irq_q)
    else $error("status read left interrupt pending");
  shadow_keep_a: assert property (
    ce && host_rd && host_offset == 4'hE && irq_q && !$past(host_rd) &&
    !$past(host_wr) |=> irq_q)
    else $error("shadow read cleared interrupt");
  mask_irq_a: assert property (
    ctl_wr && host_wdata[1] |-> ##2 !irq_q [*2])
    else $error("interrupt not masked");
endmodule // tf_checker
`default_nettype wire

// File: sim/host_bus_model.sv
// Host adapter model issuing single-byte task-file cycles
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic clk,
  output logic host_rd,
  output logic host_wr,
  output logic [3:0] host_offset,
  output logic even_byte_n,
  output logic odd_byte_n,
  output logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic host_rdata_oe
);
  // ===================================================================
  // Idle bus: strobes low, lanes off
  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_offset = 4'h0;
    even_byte_n = 1'b1;
    odd_byte_n = 1'b1;
    host_wdata = 16'h0000;
  end
  // Lane select, odd-only moves the byte to D15-D8
  task automatic lanes(input logic [3:0] off, input logic odd);
    host_offset = off;
    even_byte_n = odd;
    odd_byte_n = !odd;
  endtask
  // Release: stale data inverted so it never looks valid
  task automatic release_bus();
    host_wdata = ~host_wdata;
    host_offset = ~host_offset;
    even_byte_n = 1'b1;
    odd_byte_n = 1'b1;
  endtask
  // One-cycle write strobe, changed only at falling edges
  task automatic wr(input logic [3:0] off, input logic [7:0] d,
                    input logic odd);
    if (off == 4'hF) return; // Drive address is never written
    @(negedge clk);
    lanes(off, odd);
    host_wdata = odd ? {d, 8'h00} : {8'h00, d};
    host_wr = 1'b1;
    @(negedge clk);
    host_wr = 1'b0;
    release_bus();
  endtask
  // Read: data and enable stand in the cycle after the strobe
  task automatic rd(input logic [3:0] off, input logic odd,
                    output logic [7:0] d, output logic oe);
    @(negedge clk);
    lanes(off, odd);
    host_rd = 1'b1;
    @(negedge clk);
    host_rd = 1'b0;
    d = odd ? host_rdata[15:8] : host_rdata[7:0];
    oe = host_rdata_oe;
    release_bus();
  endtask
endmodule // host_bus_model
`default_nettype wire

// File: sim/tb_ata_task_file_registers.sv
// Self-checking bench for the task-file register bank
`timescale 1ns/1ps
`default_nettype none
module tb_ata_task_file_registers;
  // ===================================================================
  // Clock, reset and controller-side stimulus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // Held high except for the one frozen-enable count write
  logic copy_pin = 1'b0, cmd_failed = 1'b0, write_active = 1'b0;
  logic [9:0] ev = 10'h000; // One bit per controller event pulse
  logic [7:0] fail_cause = 8'h00, remain_count = 8'h00, d, feat;
  logic [27:0] fail_addr = 28'h0000000;
  logic oe, sel, sr, irq, lba;
  logic [8:0] sectors;
  logic [27:0] start;
  wire logic host_rd, host_wr, even_byte_n, odd_byte_n, host_rdata_oe;
  wire logic [3:0] host_offset;
  wire logic [15:0] host_wdata, host_rdata;
  int err_total = 0;
  int n_compared = 0;
  typedef struct packed {
    logic [3:0] off;
    logic [7:0] wd;
    logic [7:0] rx;
  } row_t;
  // Write then read back; error reads zero, unmapped offset reads zero
  row_t rows [8] = '{'{4'h2, 8'h00, 8'h00}, '{4'h3, 8'h5A, 8'h5A},
    '{4'h4, 8'hA5, 8'hA5}, '{4'h5, 8'h3C, 8'h3C}, '{4'h6, 8'h4B, 8'hEB},
    '{4'hA, 8'hFF, 8'h00}, '{4'h1, 8'h77, 8'h00}, '{4'hD, 8'h66, 8'h00}};
  always #5 clk = ~clk;
  // ===================================================================
  // Device and host adapter
  host_bus_model u_host (.clk(clk), .host_rd(host_rd), .host_wr(host_wr),
    .host_offset(host_offset), .even_byte_n(even_byte_n),
    .odd_byte_n(odd_byte_n), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe));
  ata_task_file_registers u_dut (.clk(clk), .rst(rst), .ce(ce),
    .host_rd(host_rd), .host_wr(host_wr), .host_offset(host_offset),
    .even_byte_n(even_byte_n), .odd_byte_n(odd_byte_n),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .copy_number_pin(copy_pin),
    .cmd_start(ev[0]), .busy_set(ev[1]), .busy_clear(ev[2]),
    .ready_set(ev[3]), .xfer_req_set(ev[4]), .xfer_req_clear(ev[5]),
    .corrected_set(ev[6]), .write_fault_set(ev[7]),
    .write_active(write_active),
    .cmd_done(ev[8]), .cmd_failed(cmd_failed), .fail_cause(fail_cause),
    .remain_count(remain_count), .fail_addr(fail_addr), .irq_event(ev[9]),
    .feature_q(feat), .count_q(), .sectors_q(sectors), .lba_mode_q(lba),
    .start_addr_q(start), .selected_q(sel), .soft_reset_q(sr), .irq_q(irq));
  // ===================================================================
  // Helpers
  task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Event pulses last one cycle; register effects land before return, irq_q one cycle later
  task automatic fire(input logic [9:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 10'h000;
  endtask
  task automatic rdc(input logic [3:0] off, input logic odd,
                     input logic [7:0] x);
    u_host.rd(off, odd, d, oe);
    chk(oe, 1'b1);
    chk(d, x);
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the roughly 150 cycles used
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  // ===================================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rdc(4'h2, 1'b0, 8'h01);
    rdc(4'h7, 1'b0, 8'h00);
    chk({sectors, irq, sr}, {9'h001, 2'b00});
    foreach (rows[i]) begin
      u_host.wr(rows[i].off, rows[i].wd, 1'b0);
      rdc(rows[i].off, 1'b0, rows[i].rx);
    end
    chk({feat, sectors, lba, sel},
        {8'h66, 9'h100, 2'b11});
    chk(start, 28'hB3CA55A);
    rdc(4'hF, 1'b0, 8'h52);
    copy_pin = 1'b1;
    repeat (8) @(negedge clk);
    rdc(4'hF, 1'b0, 8'h53);
    u_host.wr(4'h6, 8'h5B, 1'b0);
    write_active = 1'b1;
    rdc(4'hF, 1'b0, 8'h11);
    chk(sel, 1'b1);
    write_active = 1'b0;
    fire(10'h008);
    rdc(4'h7, 1'b0, 8'h50);
    // Busy: address writes refused, control writes taken
    fire(10'h001);
    u_host.rd(4'h7, 1'b0, d, oe);
    chk(d[7], 1'b1); // Other bits invalid while busy
    u_host.wr(4'h3, 8'h99, 1'b0);
    u_host.wr(4'hE, 8'h02, 1'b0);
    fire(10'h200);
    @(negedge clk); // Pending is now set, so the mask is what holds it low
    chk(irq, 1'b0);
    u_host.wr(4'hE, 8'h00, 1'b0);
    @(negedge clk);
    chk(irq, 1'b1);
    u_host.rd(4'hE, 1'b0, d, oe);
    chk(irq, 1'b1);
    u_host.rd(4'h7, 1'b0, d, oe);
    @(negedge clk);
    chk(irq, 1'b0);
    fire(10'h0D0);
    fire(10'h004);
    rdc(4'hE, 1'b0, 8'h7C);
    rdc(4'h3, 1'b0, 8'h5A);
    fire(10'h020);
    // Failed command with every cause bit offered
    cmd_failed = 1'b1;
    fail_cause = 8'hFF;
    remain_count = 8'h03;
    fail_addr = 28'h1234567;
    fire(10'h100);
    cmd_failed = 1'b0;
    rdc(4'h7, 1'b0, 8'h75);
    rdc(4'h1, 1'b0, 8'hD5);
    rdc(4'hD, 1'b0, 8'hD5);
    rdc(4'h0, 1'b1, 8'hD5);
    rdc(4'h2, 1'b0, 8'h03);
    rdc(4'h3, 1'b0, 8'h67);
    rdc(4'h5, 1'b0, 8'h23);
    rdc(4'h6, 1'b0, 8'hF1);
    fire(10'h001);
    fire(10'h004);
    rdc(4'h7, 1'b0, 8'h50);
    fire(10'h100);
    rdc(4'h2, 1'b0, 8'h00);
    u_host.wr(4'h0, 8'h9C, 1'b1);
    chk({feat, sectors}, {8'h9C, 9'h100});
    u_host.wr(4'hE, 8'h04, 1'b0);
    chk(sr, 1'b1);
    rdc(4'h7, 1'b0, 8'h00);
    rdc(4'h1, 1'b0, 8'h01);
    u_host.wr(4'hE, 8'h00, 1'b0);
    chk(sr, 1'b0);
    // Frozen clock enable: a count write must not land
    ce = 1'b0;
    u_host.wr(4'h2, 8'h55, 1'b0);
    ce = 1'b1;
    rdc(4'h2, 1'b0, 8'h01);
    // Reset in mid-run with an interrupt pending and a count loaded
    u_host.wr(4'h2, 8'h42, 1'b0);
    fire(10'h200);
    @(negedge clk);
    chk(irq, 1'b1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({sectors, irq, sr, lba, feat},
        {9'h001, 3'b000, 8'h00});
    rdc(4'h2, 1'b0, 8'h01);
    rdc(4'h7, 1'b0, 8'h00);
    end_sim();
  end
endmodule // tb_ata_task_file_registers
bind ata_task_file_registers tf_checker u_chk (.clk(clk), .rst(rst),
  .ce(ce), .host_rd(host_rd), .host_wr(host_wr), .host_offset(host_offset),
  .even_byte_n(even_byte_n), .host_wdata(host_wdata),
  .host_rdata_oe(host_rdata_oe), .cmd_done(cmd_done),
  .cmd_failed(cmd_failed), .remain_count(remain_count),
  .irq_event(irq_event), .count_q(count_q), .sectors_q(sectors_q),
  .soft_reset_q(soft_reset_q), .irq_q(irq_q));
`default_nettype wire
